// ===== rtl/phyec_fifo.sv
// module: transmit nibble fifo with valid and ready on both sides
`timescale 1ns/1ps
module phyec_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 16
) (
   input wire logic clk_in, // clock
   input wire logic rst_in, // asynchronous reset, active high
   input wire logic flush_in, // empties the fifo
   input wire logic wr_valid_in, // write side offers a word
   input wire logic [WIDTH-1:0] wr_data_in, // write data
   output logic wr_ready_out, // fifo has room
   output logic rd_valid_out, // fifo holds a word
   output logic [WIDTH-1:0] rd_data_out, // head word
   input wire logic rd_ready_in // read side takes the head word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic full;
   logic empty;

   // the extra pointer bit tells full from empty
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign wr_ready_out = !full;
   assign rd_valid_out = !empty;
   assign rd_data_out = mem[rd_ptr_r[AW-1:0]];

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else if (flush_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end
      else
      begin
         if (wr_valid_in && !full)
         begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (rd_ready_in && !empty)
         begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   // storage needs no reset; unread entries are never shown as valid
   always_ff @(posedge clk_in)
   begin
      if (wr_valid_in && !full)
      begin
         mem[wr_ptr_r[AW-1:0]] <= wr_data_in;
      end
   end

endmodule

// ===== rtl/phyec_pkg.sv
// package: constants, code tables and carrier types of the phy extended control block
package phyec_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map and field positions
   localparam logic [4:0] PHYEC_REG_EXT_CTRL = 5'h10;
   localparam int PHYEC_BIT_OW_EN = 15;
   localparam int PHYEC_BIT_ADDR_HI = 10;
   localparam int PHYEC_BIT_ADDR_LO = 6;
   localparam int PHYEC_BIT_SCR_TEST = 5;
   localparam int PHYEC_BIT_NRZI = 3;
   localparam int PHYEC_BIT_INV_TEST = 2;
   localparam int PHYEC_BIT_SCR_DIS = 0;

   // values after reset of the writable fields
   localparam logic PHYEC_RST_OW_EN = 1'h0;
   localparam logic PHYEC_RST_SCR_TEST = 1'h0;
   localparam logic PHYEC_RST_NRZI = 1'h1;
   localparam logic PHYEC_RST_INV_TEST = 1'h0;
   localparam logic PHYEC_RST_SCR_DIS = 1'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // management frame counts, in mdc cycles, and opcodes
   localparam logic [5:0] PHYEC_PREAMBLE_LEN = 6'h20;
   localparam logic [5:0] PHYEC_HDR_LAST = 6'h0C;
   localparam logic [5:0] PHYEC_TA_LAST = 6'h01;
   localparam logic [5:0] PHYEC_DATA_LAST = 6'h0F;
   localparam logic [1:0] PHYEC_OP_READ = 2'h2;
   localparam logic [1:0] PHYEC_OP_WRITE = 2'h1;

   // transmit path
   localparam int PHYEC_FIFO_WIDTH = 5;
   localparam int PHYEC_FIFO_DEPTH = 16;
   localparam logic [10:0] PHYEC_LFSR_SEED = 11'h7FF;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [3:0] {
      PHYEC_IDLE = 4'h1,
      PHYEC_HDR = 4'h2,
      PHYEC_TA = 4'h4,
      PHYEC_DATA = 4'h8
   } phyec_mdio_state_type;

   typedef struct packed {
      logic err;
      logic [3:0] nib;
   } phyec_tx_word_type;

   typedef struct packed {
      logic ow_en;
      logic scr_test;
      logic nrzi;
      logic inv_test;
      logic scr_dis;
   } phyec_ctrl_type;

   localparam phyec_ctrl_type PHYEC_CTRL_RESET = '{
      ow_en: PHYEC_RST_OW_EN,
      scr_test: PHYEC_RST_SCR_TEST,
      nrzi: PHYEC_RST_NRZI,
      inv_test: PHYEC_RST_INV_TEST,
      scr_dis: PHYEC_RST_SCR_DIS
   };

   typedef struct packed {
      logic mdc_q;
      phyec_mdio_state_type st;
      logic [5:0] cnt;
      logic [15:0] shreg;
      logic rd;
      logic hit;
      logic [4:0] regad;
      logic mdio_o;
      logic mdio_oe;
      phyec_ctrl_type ctl;
      logic addr_latched;
      logic [4:0] phy_addr;
      logic wr_pulse;
      logic wr_override;
      logic [4:0] wr_reg;
      logic [15:0] wr_data;
      logic [10:0] lfsr;
      logic nrzi_lvl;
      logic sym_valid;
      logic [4:0] sym;
   } phyec_state_type;

   ////////////////////////////////////////////////////////////////////////////////
   // code tables
   function automatic logic [4:0] phyec_std_code(input logic [3:0] nib);
      logic [4:0] c;
      c = 5'h1E;
      unique case (nib)
         4'h0: c = 5'h1E;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0A;
         4'h5: c = 5'h0B;
         4'h6: c = 5'h0E;
         4'h7: c = 5'h0F;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'hA: c = 5'h16;
         4'hB: c = 5'h17;
         4'hC: c = 5'h1A;
         4'hD: c = 5'h1B;
         4'hE: c = 5'h1C;
         4'hF: c = 5'h1D;
      endcase
      return c;
   endfunction

   function automatic logic [4:0] phyec_sub_code(input logic [3:0] nib);
      logic [4:0] c;
      c = {1'b0, nib};
      unique case (nib)
         4'h8: c = 5'h00;
         4'h9: c = 5'h0D;
         4'hA: c = 5'h0C;
         4'hB: c = 5'h11;
         4'hC: c = 5'h10;
         4'hD: c = 5'h19;
         4'hE: c = 5'h18;
         4'hF: c = 5'h1F;
         default: c = {1'b0, nib};
      endcase
      return c;
   endfunction

endpackage

// ===== rtl/phyec_top.sv
// module: extended control register with management access and transmit encoding
`timescale 1ns/1ps
module phyec_top
   import phyec_pkg::*;
(
   input wire logic clk_in, // management clock, 200 MHz
   input wire logic rst_in, // hardware or power-on reset, async, active high
   input wire logic sw_reset_in, // software reset, level, active high
   input wire logic mdc_in, // management data clock, sampled
   input wire logic mdio_in, // management data pin, input side
   output logic mdio_out, // management data pin, output side
   output logic mdio_oe_out, // management data pin, high while driven
   input wire logic addr4_led_pin_in, // led pin sampled as address bit 4
   input wire logic addr3_led_pin_in, // led pin sampled as address bit 3
   input wire logic addr2_led_pin_in, // led pin sampled as address bit 2
   input wire logic addr1_led_pin_in, // led pin sampled as address bit 1
   input wire logic addr0_led_pin_in, // led pin sampled as address bit 0
   input wire logic speed_100_in, // high in 100 Mb/s operation
   input wire logic tx_valid_in, // mac offers a transmit nibble
   input wire phyec_pkg::phyec_tx_word_type tx_word_in, // transmit nibble with its error flag
   output logic tx_ready_out, // transmit nibble accepted
   output logic sym_valid_out, // coded symbol available
   output logic [4:0] sym_out, // coded five-bit symbol, first bit in bit 4
   input wire logic sym_ready_in, // symbol sink takes the symbol
   output logic descr_bypass_out, // receive descrambler bypassed
   output logic descr_unlock_out, // forces descrambler out of lock
   output logic [4:0] phy_addr_out, // latched management port address
   output logic mgmt_wr_out, // pulse: a management write completed
   output logic [4:0] mgmt_wr_reg_out, // register of that write
   output logic [15:0] mgmt_wr_data_out, // data of that write
   output logic mgmt_wr_override_out // that write may alter protected bits
);
   import phyec_pkg::*;

   phyec_state_type state_r;
   phyec_state_type state_nxt;
   logic fifo_rd_valid;
   logic fifo_rd_ready;
   logic [4:0] fifo_rd_data;
   phyec_tx_word_type head;
   logic rise;
   logic take;
   logic scr_on;
   logic nrzi_on;
   logic [15:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////////
   // transmit buffer; its ready stalls the mac once all 16 entries are held behind a stalled symbol sink
   phyec_fifo #(
      .WIDTH(PHYEC_FIFO_WIDTH),
      .DEPTH(PHYEC_FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .flush_in(sw_reset_in),
      .wr_valid_in(tx_valid_in),
      .wr_data_in(tx_word_in),
      .wr_ready_out(tx_ready_out),
      .rd_valid_out(fifo_rd_valid),
      .rd_data_out(fifo_rd_data),
      .rd_ready_in(fifo_rd_ready)
   );

   assign head = phyec_tx_word_type'(fifo_rd_data);

   ////////////////////////////////////////////////////////////////////////////////
   // register image seen by a management read
   always_comb
   begin
      rd_word = '0;
      rd_word[PHYEC_BIT_OW_EN] = state_r.ctl.ow_en;
      rd_word[PHYEC_BIT_ADDR_HI:PHYEC_BIT_ADDR_LO] = state_r.phy_addr;
      rd_word[PHYEC_BIT_SCR_TEST] = state_r.ctl.scr_test;
      rd_word[PHYEC_BIT_NRZI] = state_r.ctl.nrzi;
      rd_word[PHYEC_BIT_INV_TEST] = state_r.ctl.inv_test;
      rd_word[PHYEC_BIT_SCR_DIS] = state_r.ctl.scr_dis;
   end

   assign rise = mdc_in && !state_r.mdc_q;
   assign scr_on = speed_100_in && !state_r.ctl.scr_dis;
   assign nrzi_on = speed_100_in && state_r.ctl.nrzi;
   assign take = fifo_rd_valid && (!state_r.sym_valid || sym_ready_in);
   assign fifo_rd_ready = take;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [15:0] word;
      logic [4:0] code;
      logic [10:0] lfsr;
      logic lvl;
      logic fb;
      logic [1:0] op;
      word = '0;
      code = '0;
      lfsr = state_r.lfsr;
      lvl = state_r.nrzi_lvl;
      fb = 1'b0;
      op = '0;
      state_nxt = state_r;
      state_nxt.mdc_q = mdc_in;
      state_nxt.wr_pulse = 1'b0;
      state_nxt.wr_override = 1'b0;

      // straps caught on the first edge after hardware reset release only
      if (!state_r.addr_latched)
      begin
         state_nxt.addr_latched = 1'b1;
         state_nxt.phy_addr = {addr4_led_pin_in, addr3_led_pin_in, addr2_led_pin_in,
                               addr1_led_pin_in, addr0_led_pin_in};
      end

      // management frame engine; preamble suppression is not supported
      if (sw_reset_in)
      begin
         state_nxt.ctl = PHYEC_CTRL_RESET; // address left alone
         state_nxt.st = PHYEC_IDLE;
         state_nxt.cnt = '0;
         state_nxt.mdio_oe = 1'b0;
         state_nxt.mdio_o = 1'b0;
      end
      else if (rise)
      begin
         unique case (state_r.st)
            PHYEC_IDLE:
            begin
               if (mdio_in)
               begin
                  if (state_r.cnt != PHYEC_PREAMBLE_LEN)
                  begin
                     state_nxt.cnt = state_r.cnt + 6'h01;
                  end
               end
               else if (state_r.cnt == PHYEC_PREAMBLE_LEN)
               begin
                  state_nxt.st = PHYEC_HDR;
                  state_nxt.cnt = '0;
                  state_nxt.shreg = '0;
               end
               else
               begin
                  state_nxt.cnt = '0;
               end
            end
            PHYEC_HDR:
            begin
               word = {state_r.shreg[14:0], mdio_in};
               state_nxt.shreg = word;
               state_nxt.cnt = state_r.cnt + 6'h01;
               if (state_r.cnt == PHYEC_HDR_LAST)
               begin
                  op = word[11:10];
                  state_nxt.cnt = '0;
                  state_nxt.rd = (op == PHYEC_OP_READ);
                  state_nxt.hit = (word[9:5] == state_r.phy_addr);
                  state_nxt.regad = word[4:0];
                  // a bad start or opcode drops the frame
                  if (word[12] && (op == PHYEC_OP_READ || op == PHYEC_OP_WRITE))
                  begin
                     state_nxt.st = PHYEC_TA;
                  end
                  else
                  begin
                     state_nxt.st = PHYEC_IDLE;
                  end
               end
            end
            PHYEC_TA:
            begin
               state_nxt.cnt = state_r.cnt + 6'h01;
               if (state_r.rd && state_r.hit)
               begin
                  state_nxt.mdio_oe = 1'b1;
                  state_nxt.mdio_o = 1'b0;
               end
               if (state_r.cnt == PHYEC_TA_LAST)
               begin
                  state_nxt.st = PHYEC_DATA;
                  state_nxt.cnt = '0;
                  if (state_r.rd && state_r.hit)
                  begin
                     // only this register exists here; others read as zero
                     word = (state_r.regad == PHYEC_REG_EXT_CTRL) ? rd_word : 16'h0000;
                     state_nxt.mdio_o = word[15];
                     state_nxt.shreg = {word[14:0], 1'b0};
                  end
               end
            end
            PHYEC_DATA:
            begin
               state_nxt.cnt = state_r.cnt + 6'h01;
               if (state_r.rd)
               begin
                  state_nxt.mdio_o = state_r.shreg[15];
                  state_nxt.shreg = {state_r.shreg[14:0], 1'b0};
               end
               else
               begin
                  state_nxt.shreg = {state_r.shreg[14:0], mdio_in};
               end
               if (state_r.cnt == PHYEC_DATA_LAST)
               begin
                  state_nxt.st = PHYEC_IDLE;
                  state_nxt.cnt = '0;
                  state_nxt.mdio_oe = 1'b0;
                  state_nxt.mdio_o = 1'b0;
                  if (!state_r.rd && state_r.hit)
                  begin
                     word = {state_r.shreg[14:0], mdio_in};
                     state_nxt.wr_pulse = 1'b1;
                     state_nxt.wr_reg = state_r.regad;
                     state_nxt.wr_data = word;
                     state_nxt.wr_override = state_r.ctl.ow_en;
                     // any completed write to this port's address spends the enable
                     state_nxt.ctl.ow_en = 1'b0;
                     if (state_r.regad == PHYEC_REG_EXT_CTRL)
                     begin
                        // reserved bits are dropped, relying on zero writes
                        state_nxt.ctl.ow_en = word[PHYEC_BIT_OW_EN];
                        state_nxt.ctl.scr_test = word[PHYEC_BIT_SCR_TEST];
                        state_nxt.ctl.nrzi = word[PHYEC_BIT_NRZI];
                        state_nxt.ctl.inv_test = word[PHYEC_BIT_INV_TEST];
                        state_nxt.ctl.scr_dis = word[PHYEC_BIT_SCR_DIS];
                     end
                  end
               end
            end
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////
      // transmit coding: 4b5b or substitute, then scramble, then nrzi
      if (sw_reset_in)
      begin
         state_nxt.sym_valid = 1'b0;
         state_nxt.lfsr = PHYEC_LFSR_SEED;
         state_nxt.nrzi_lvl = 1'b0;
      end
      else if (take)
      begin
         if (state_r.ctl.inv_test && head.err)
         begin
            code = phyec_sub_code(head.nib);
         end
         else
         begin
            code = phyec_std_code(head.nib);
         end
         // bit 4 leaves first, so it meets the earliest key bit
         for (int i = 4; i >= 0; i--)
         begin
            if (scr_on)
            begin
               fb = lfsr[10] ^ lfsr[8];
               code[i] = code[i] ^ fb;
               lfsr = {lfsr[9:0], fb};
            end
            if (nrzi_on)
            begin
               lvl = lvl ^ code[i];
               code[i] = lvl;
            end
         end
         state_nxt.lfsr = lfsr;
         state_nxt.nrzi_lvl = lvl;
         state_nxt.sym = code;
         state_nxt.sym_valid = 1'b1;
      end
      else if (sym_ready_in)
      begin
         state_nxt.sym_valid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r <= '0;
         state_r.st <= PHYEC_IDLE;
         state_r.ctl <= PHYEC_CTRL_RESET;
         state_r.lfsr <= PHYEC_LFSR_SEED;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign mdio_out = state_r.mdio_o;
   assign mdio_oe_out = state_r.mdio_oe;
   assign sym_valid_out = state_r.sym_valid;
   assign sym_out = state_r.sym;
   assign descr_bypass_out = !scr_on;
   assign descr_unlock_out = state_r.ctl.scr_test;
   assign phy_addr_out = state_r.phy_addr;
   assign mgmt_wr_out = state_r.wr_pulse;
   assign mgmt_wr_reg_out = state_r.wr_reg;
   assign mgmt_wr_data_out = state_r.wr_data;
   assign mgmt_wr_override_out = state_r.wr_override;

endmodule

// ===== tb/phyec_sta_model.sv
// partner: station management entity sending management frames
`timescale 1ns/1ps
module phyec_sta_model (
   input wire logic clk_in, // bench clock
   input wire logic mdio_in, // resolved mdio wire
   output logic mdc_out, // management clock, still between frames
   output logic mdio_out, // drive value
   output logic mdio_oe_out, // high while driving
   output logic rd_done_out, // pulse: read data ready
   output logic [15:0] rd_data_out // data sampled in the data phase of the last frame, read or write
);
   initial
   begin
      mdc_out = 1'b0;
      mdio_out = 1'b1;
      mdio_oe_out = 1'b0;
      rd_done_out = 1'b0;
      rd_data_out = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // data is set up while mdc is low and sampled just before it rises
   task automatic bit_cycle(input logic b, input logic drive, output logic s);
      @(posedge clk_in);
      mdc_out <= 1'b0;
      mdio_out <= b;
      mdio_oe_out <= drive;
      repeat (2) @(posedge clk_in);
      s = mdio_in;
      mdc_out <= 1'b1;
      @(posedge clk_in);
   endtask
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
      input logic [15:0] d);
      logic [45:0] hdr;
      logic [15:0] wd;
      logic [15:0] r;
      logic s;
      logic wrt;
      wrt = (op == 2'h1);
      hdr = {32'hFFFFFFFF, 2'h1, op, phy, rg};
      wd = (rg == 5'h10) ? (d & 16'h87ED) : d;
      for (int i = 45; i >= 0; i--)
         bit_cycle(hdr[i], 1'b1, s);
      bit_cycle(1'b1, wrt, s);
      bit_cycle(1'b0, wrt, s);
      for (int i = 15; i >= 0; i--)
      begin
         bit_cycle(wd[i], wrt, s);
         r[i] = s;
      end
      @(posedge clk_in);
      mdc_out <= 1'b0;
      mdio_oe_out <= 1'b0;
      rd_data_out <= r;
      rd_done_out <= !wrt;
      @(posedge clk_in);
      rd_done_out <= 1'b0;
   endtask
endmodule

// ===== tb/phyec_top_properties.sv
// checker: port properties of the phy extended control block
`timescale 1ns/1ps
module phyec_top_props
   import phyec_pkg::*;
(
   input wire logic clk_in, // clock
   input wire logic rst_in, // async reset
   input wire logic sw_reset_in, // software reset
   input wire logic speed_100_in, // 100 mode
   input wire logic mdio_oe_out, // mdio enable
   input wire logic sym_valid_out, // symbol valid
   input wire logic descr_bypass_out, // bypass
   input wire logic descr_unlock_out, // unlock
   input wire logic [4:0] phy_addr_out, // address
   input wire logic mgmt_wr_out, // write pulse
   input wire logic [4:0] mgmt_wr_reg_out, // write register
   input wire logic [15:0] mgmt_wr_data_out, // write data
   input wire logic mgmt_wr_override_out // write override
);
   logic [1:0] age_r;
   logic ow_r;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_ctl_write;
      mgmt_wr_out && mgmt_wr_reg_out == PHYEC_REG_EXT_CTRL;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   // ow_r predicts the override enable from completed writes and software reset alone
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         age_r <= 2'h0;
         ow_r <= 1'b0;
      end
      else
      begin
         age_r <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
         if (sw_reset_in)
            ow_r <= 1'b0;
         else if (mgmt_wr_out)
            ow_r <= (mgmt_wr_reg_out == PHYEC_REG_EXT_CTRL) && mgmt_wr_data_out[PHYEC_BIT_OW_EN];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_addr_stable: assert property (age_r == 2'h3 |-> $stable(phy_addr_out))
      else $error("port address moved after reset");
   a_override_once: assert property (mgmt_wr_out |-> mgmt_wr_override_out == ow_r)
      else $error("override flag of a write is wrong");
   a_wr_pulse: assert property (mgmt_wr_out |=> !mgmt_wr_out)
      else $error("write pulse longer than one cycle");
   a_unlock_follow: assert property (s_ctl_write |=>
      descr_unlock_out == mgmt_wr_data_out[PHYEC_BIT_SCR_TEST])
      else $error("unlock does not follow the test bit");
   a_bypass_dis: assert property (s_ctl_write ##0 speed_100_in |=>
      descr_bypass_out == mgmt_wr_data_out[PHYEC_BIT_SCR_DIS])
      else $error("bypass does not follow the disable bit");
   a_bypass_slow: assert property (!speed_100_in |-> descr_bypass_out)
      else $error("scrambling active at 10");
   a_sw_defaults: assert property (sw_reset_in |-> ##[1:2] (!descr_unlock_out && !sym_valid_out))
      else $error("software reset left test mode or a symbol");
   a_reset_defaults: assert property ($fell(rst_in) |-> !descr_unlock_out && !mdio_oe_out &&
      !mgmt_wr_out && descr_bypass_out == !speed_100_in)
      else $error("wrong state after reset");
endmodule
bind phyec_top phyec_top_props i_props (.clk_in(clk_in), .rst_in(rst_in),
   .sw_reset_in(sw_reset_in), .speed_100_in(speed_100_in), .mdio_oe_out(mdio_oe_out),
   .sym_valid_out(sym_valid_out), .descr_bypass_out(descr_bypass_out),
   .descr_unlock_out(descr_unlock_out), .phy_addr_out(phy_addr_out), .mgmt_wr_out(mgmt_wr_out),
   .mgmt_wr_reg_out(mgmt_wr_reg_out), .mgmt_wr_data_out(mgmt_wr_data_out),
   .mgmt_wr_override_out(mgmt_wr_override_out));

// ===== tb/tb_phy_extended_control.sv
// testbench: register access and transmit coding of the phy extended control block
`timescale 1ns/1ps
module tb_phy_extended_control;
   import phyec_pkg::*;
   localparam logic [4:0] ADDR = 5'h15;
   localparam int LIMIT = 20000;
   localparam logic [4:0] STD [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   localparam logic [4:0] SUB [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
      5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic sw_reset_in = 1'b0;
   logic speed_100_in = 1'b1;
   logic [4:0] pins = ADDR;
   logic tx_valid_in = 1'b0;
   phyec_tx_word_type tx_word_in = '0;
   logic sym_ready_in = 1'b0;
   logic stall = 1'b0, ovr_q = 1'b0, wr_p;
   logic mdc, sta_o, sta_oe, dut_o, dut_oe, mdio_w, rd_done, tx_ready_out, sym_valid_out, ovr;
   logic [4:0] sym_out;
   logic [15:0] rd_data;
   logic [31:0] rnd = 32'hA7E9AF40;
   logic [10:0] m_lfsr = 11'h7FF;
   logic m_lvl = 1'b0, m_inv = 1'b0, m_dis = 1'b0, m_nrzi = 1'b1;
   logic [4:0] exp_sym [$];
   logic [15:0] exp_rd [$];
   int fails = 0, n_compared = 0, cycles = 0;
   always #2.5 clk_in = ~clk_in;
   assign mdio_w = dut_oe ? dut_o : (sta_oe ? sta_o : 1'b1); // pull-up when nobody drives
   phyec_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .sw_reset_in(sw_reset_in), .mdc_in(mdc),
      .mdio_in(mdio_w), .mdio_out(dut_o), .mdio_oe_out(dut_oe), .addr4_led_pin_in(pins[4]),
      .addr3_led_pin_in(pins[3]), .addr2_led_pin_in(pins[2]), .addr1_led_pin_in(pins[1]),
      .addr0_led_pin_in(pins[0]), .speed_100_in(speed_100_in), .tx_valid_in(tx_valid_in),
      .tx_word_in(tx_word_in), .tx_ready_out(tx_ready_out), .sym_valid_out(sym_valid_out),
      .sym_out(sym_out), .sym_ready_in(sym_ready_in), .descr_bypass_out(), .descr_unlock_out(),
      .phy_addr_out(), .mgmt_wr_out(wr_p), .mgmt_wr_reg_out(), .mgmt_wr_data_out(),
      .mgmt_wr_override_out(ovr));
   phyec_sta_model i_sta (.clk_in(clk_in), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_out(sta_o),
      .mdio_oe_out(sta_oe), .rd_done_out(rd_done), .rd_data_out(rd_data));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] rg, input logic [15:0] d);
      if (rg == 5'h10)
         {m_nrzi, m_inv, m_dis} = {d[3], d[2], d[0]};
      i_sta.frame(2'h1, ADDR, rg, d);
   endtask
   task automatic rd(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
      exp_rd.push_back(exp);
      i_sta.frame(2'h2, phy, rg, 16'h0000);
   endtask
   // expected symbol: table, then scrambler, then nrzi, bit 4 first
   task automatic send(input phyec_tx_word_type w);
      logic [4:0] c;
      logic k;
      c = (m_inv && w.err) ? SUB[w.nib] : STD[w.nib];
      for (int b = 4; b >= 0; b--)
      begin
         k = m_lfsr[10] ^ m_lfsr[8];
         if (speed_100_in && !m_dis)
         begin
            m_lfsr = {m_lfsr[9:0], k};
            c[b] = c[b] ^ k;
         end
         if (speed_100_in && m_nrzi)
         begin
            m_lvl = m_lvl ^ c[b];
            c[b] = m_lvl;
         end
      end
      exp_sym.push_back(c);
      tx_valid_in <= 1'b1;
      tx_word_in <= w;
      @(posedge clk_in);
      while (tx_ready_out !== 1'b1)
         @(posedge clk_in);
   endtask
   task automatic drain();
      tx_valid_in <= 1'b0;
      for (int i = 0; i < 600 && exp_sym.size() != 0; i++)
         @(posedge clk_in);
      check("sym_drained", 16'(exp_sym.size()), 16'h0000);
   endtask
   task automatic batch(input int n);
      for (int i = 0; i < n; i++)
         send(rnd[4:0]);
      drain();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in)
   begin
      rnd <= xs(rnd);
      sym_ready_in <= !stall && (rnd[1:0] != 2'h0);
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fails++;
         give_verdict();
      end
   end
   always @(posedge clk_in)
   begin
      if (sym_valid_out === 1'b1 && sym_ready_in === 1'b1)
      begin
         if (exp_sym.size() == 0)
            check("sym_unexpected", 16'h0001, 16'h0000);
         else
            check("sym_out", {11'h000, sym_out}, {11'h000, exp_sym.pop_front()});
      end
      if (rd_done === 1'b1)
         check("mdio_read", rd_data, exp_rd.pop_front());
      if (wr_p === 1'b1)
         ovr_q <= ovr;
   end
   initial
   begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      pins <= ~ADDR; // straps move after reset and must not reach the address
      rd(ADDR, 5'h10, {1'b0, 4'h0, ADDR, 6'h08});
      batch(12);
      wr(5'h10, 16'h8025);
      rd(ADDR, 5'h10, {1'b1, 4'h0, ADDR, 6'h25});
      wr(5'h00, 16'h0000);
      check("override_used", {15'h0000, ovr_q}, 16'h0001);
      rd(ADDR, 5'h10, {1'b0, 4'h0, ADDR, 6'h25});
      wr(5'h01, 16'h0000);
      check("override_gone", {15'h0000, ovr_q}, 16'h0000);
      wr(5'h10, 16'h8025);
      wr(5'h02, 16'h0000);
      check("override_again", {15'h0000, ovr_q}, 16'h0001);
      stall <= 1'b1;
      @(posedge clk_in);
      for (int i = 0; i < 16; i++)
         send({1'b1, 4'(i)});
      send(5'h0F);
      tx_valid_in <= 1'b0;
      @(posedge clk_in);
      check("tx_ready_full", {15'h0000, tx_ready_out}, 16'h0000);
      stall <= 1'b0;
      drain();
      speed_100_in <= 1'b0;
      wr(5'h10, 16'h0004);
      batch(24);
      wr(5'h10, 16'h0008);
      batch(16);
      wr(5'h10, 16'h0021);
      sw_reset_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      sw_reset_in <= 1'b0;
      rd(ADDR, 5'h10, {1'b0, 4'h0, ADDR, 6'h08});
      rd(ADDR, 5'h1F, 16'h0000);
      rd(ADDR ^ 5'h01, 5'h10, 16'hFFFF);
      repeat (2) @(posedge clk_in);
      give_verdict();
   end
endmodule
